// file: src/pldb_logic_block.sv
// pld logic block: product-term arrays, control terms, macrocells, register access
//
// Summary of operation
// - block takes 36 interconnect inputs and holds 16 macrocells
// - block returns 32 feedback signals, from macrocells and from pins
// - six control terms, each a sum or a product, shared by all macrocells
// - fast array has fixed or plane; shared array has programmable or plane
// - each macrocell owns five fast product terms
// - 32 shared terms routable to any macrocell, up to 37 per output
// - one shared term may feed several macrocells at once
// - each flip-flop works as d type or t type
// - each flip-flop captures on rising or falling edge of its clock
// - four clock sources; clock zero is the external dedicated clock
// - clocks one to three come from a pin or a macrocell equation
// - control terms zero and one give preset and reset
// - preset/reset can be disabled per macrocell
// - power-on reset leaves every flip-flop at zero
// - control terms two to five selectable as output enable per macrocell
// - output buffer may be always enabled or always disabled instead
// - with float enabled and float pin low, every output floats
// - two feedbacks per macrocell: logic value before buffer, pin after
// - pin used as input has buffer off and pin value fed back
// - configurable pull-down, on for pins used neither as input nor output
`timescale 1ns/1ps
module pldb_logic_block (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [pldb_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [pldb_pkg::N_IN-1:0] i_global_interconnect_array,
    input wire logic i_dedicated_sync_clock,
    input wire logic i_selectable_clock_one,
    input wire logic i_selectable_clock_two,
    input wire logic i_selectable_clock_three,
    input wire logic i_global_output_float_pin_n,
    input wire logic [pldb_pkg::N_MC-1:0] i_pin_in,
    output logic [pldb_pkg::N_MC-1:0] o_pin_out,
    output logic [pldb_pkg::N_MC-1:0] o_pin_oe,
    output logic [pldb_pkg::N_MC-1:0] o_pin_pulldown,
    output logic [pldb_pkg::N_FB-1:0] o_feedback
);
    import pldb_pkg::*;

    function automatic logic term_eval(input logic [N_IN-1:0] t, input logic [N_IN-1:0] c,
                                       input logic [N_IN-1:0] x, input logic is_sum);
        // product: and of chosen literals; sum: or of chosen literals
        term_eval = is_sum ? |((t & x) | (c & ~x)) : &((~t | x) & (~c | ~x));
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_w;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = new_w[8*b +: 8];
            end
        end
        be_merge = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic [N_IN-1:0] term_true_ff [0:N_TERM-1];
    logic [N_IN-1:0] term_comp_ff [0:N_TERM-1];
    pldb_mc_cfg_type mc_cfg_ff [0:N_MC-1];
    logic [N_SHARED-1:0] or_mask_ff [0:N_MC-1];
    pldb_glb_cfg_type glb_cfg_ff;
    logic wait_ff;
    logic [31:0] rdata_ff;
    logic [31:0] rd_word;
    logic [6:0] term_idx;
    logic [1:0] sub_idx;
    logic [3:0] mc_idx;
    logic in_term;
    logic in_mc_cfg;
    logic in_or_mask;
    logic [SYNC_W-1:0] pin_sync;
    logic [N_TERM-1:0] term_val;
    logic [N_MC-1:0] mc_logic;
    logic [N_MC-1:0] mc_logic_ff;
    logic [N_MC-1:0] mc_q;
    logic [N_MC-1:0] mc_value;
    logic [N_CLK-1:0] clk_lvl;
    logic [N_CLK-1:0] clk_prev_ff;
    logic [N_CLK-1:0] clk_rise;
    logic [N_CLK-1:0] clk_fall;
    logic [N_MC-1:0] nxt_oe;
    logic [N_MC-1:0] nxt_pd;
    logic float_active;
    logic [N_MC-1:0] pin_out_ff;
    logic [N_MC-1:0] pin_oe_ff;
    logic [N_MC-1:0] pin_pd_ff;
    logic [N_FB-1:0] feedback_ff;

    ////////////////////////////////////////////////////////////////////////////
    // register bus decode
    assign term_idx = i_avs_address[10:4];
    assign sub_idx = i_avs_address[3:2];
    assign mc_idx = i_avs_address[5:2];
    assign in_term = i_avs_address < TERM_END;
    assign in_mc_cfg = i_avs_address[11:6] == MC_CFG_BASE[11:6];
    assign in_or_mask = i_avs_address[11:6] == OR_MASK_BASE[11:6];

    // one wait cycle: request seen with wait high, answered the cycle after
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= !((i_avs_read || i_avs_write) && wait_ff);
        end
    end

    always_comb begin
        rd_word = 32'h0;
        if (in_term) begin
            case (sub_idx)
                SUB_TRUE_LO: rd_word = term_true_ff[term_idx][31:0];
                SUB_TRUE_HI: rd_word = {28'h0, term_true_ff[term_idx][35:32]};
                SUB_COMP_LO: rd_word = term_comp_ff[term_idx][31:0];
                default: rd_word = {28'h0, term_comp_ff[term_idx][35:32]};
            endcase
        end else if (in_mc_cfg) begin
            rd_word = {21'h0, mc_cfg_ff[mc_idx]};
        end else if (in_or_mask) begin
            rd_word = or_mask_ff[mc_idx];
        end else if (i_avs_address == GLB_CFG_ADDR) begin
            rd_word = glb_cfg_ff;
        end else if (i_avs_address == FEEDBACK_ADDR) begin
            rd_word = feedback_ff;
        end else if (i_avs_address == PIN_STATE_ADDR) begin
            rd_word = {15'h0, float_active, pin_oe_ff};
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_ff <= 32'h0;
        end else if (i_avs_read && wait_ff) begin
            rdata_ff <= rd_word;
        end
    end

    // writes land only on the edge where waitrequest is sampled low
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int t = 0; t < N_TERM; t++) begin
                term_true_ff[t] <= TERM_MASK_RST;
                term_comp_ff[t] <= TERM_MASK_RST;
            end
        end else if (i_avs_write && !wait_ff && in_term) begin
            case (sub_idx)
                SUB_TRUE_LO: term_true_ff[term_idx][31:0] <=
                    be_merge(term_true_ff[term_idx][31:0], i_avs_writedata, i_avs_byteenable);
                SUB_TRUE_HI: if (i_avs_byteenable[0]) begin
                    term_true_ff[term_idx][35:32] <= i_avs_writedata[3:0];
                end
                SUB_COMP_LO: term_comp_ff[term_idx][31:0] <=
                    be_merge(term_comp_ff[term_idx][31:0], i_avs_writedata, i_avs_byteenable);
                default: if (i_avs_byteenable[0]) begin
                    term_comp_ff[term_idx][35:32] <= i_avs_writedata[3:0];
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int m = 0; m < N_MC; m++) begin
                mc_cfg_ff[m] <= MC_CFG_RST;
                or_mask_ff[m] <= OR_MASK_RST;
            end
        end else if (i_avs_write && !wait_ff) begin
            if (in_mc_cfg) begin
                mc_cfg_ff[mc_idx] <= pldb_mc_cfg_type'(11'(be_merge({21'h0, mc_cfg_ff[mc_idx]},
                    i_avs_writedata, i_avs_byteenable)));
            end else if (in_or_mask) begin
                or_mask_ff[mc_idx] <= be_merge(or_mask_ff[mc_idx], i_avs_writedata, i_avs_byteenable);
            end
        end
    end

    // reserved fields are forced to zero so they read back as zero
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            glb_cfg_ff <= GLB_CFG_RST;
        end else if (i_avs_write && !wait_ff && i_avs_address == GLB_CFG_ADDR) begin
            glb_cfg_ff <= pldb_glb_cfg_type'(be_merge(glb_cfg_ff, i_avs_writedata, i_avs_byteenable)
                & 32'hfff7_013f);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins and clocks from the board
    pldb_sync #(
        .W(SYNC_W)
    ) u_pin_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async({i_pin_in, i_global_output_float_pin_n, i_selectable_clock_three,
                  i_selectable_clock_two, i_selectable_clock_one, i_dedicated_sync_clock}),
        .o_sync(pin_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // product-term arrays and control terms
    always_comb begin
        for (int t = 0; t < N_TERM; t++) begin
            term_val[t] = term_eval(term_true_ff[t], term_comp_ff[t], i_global_interconnect_array,
                (t >= CT_BASE) ? glb_cfg_ff.ct_is_sum[t - CT_BASE] : 1'b0);
        end
    end

    always_comb begin
        for (int m = 0; m < N_MC; m++) begin
            mc_logic[m] = |term_val[m*N_FAST +: N_FAST]
                | |(term_val[SHARED_BASE +: N_SHARED] & or_mask_ff[m]);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mc_logic_ff <= '0;
        end else begin
            mc_logic_ff <= mc_logic;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock sources; equation clocks take one cycle less than pin clocks
    always_comb begin
        clk_lvl[0] = pin_sync[SYNC_CLK_LSB];
        for (int k = 1; k < N_CLK; k++) begin
            clk_lvl[k] = glb_cfg_ff.clk_from_logic[k-1] ? mc_logic_ff[glb_cfg_ff.clk_mc[k-1]]
                : pin_sync[SYNC_CLK_LSB + k];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            clk_prev_ff <= '0;
        end else begin
            clk_prev_ff <= clk_lvl;
        end
    end

    assign clk_rise = clk_lvl & ~clk_prev_ff;
    assign clk_fall = ~clk_lvl & clk_prev_ff;

    ////////////////////////////////////////////////////////////////////////////
    for (genvar g = 0; g < N_MC; g++) begin : g_mc
        pldb_macrocell u_mc (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_cfg(mc_cfg_ff[g]),
            .i_logic(mc_logic[g]),
            .i_rise(clk_rise),
            .i_fall(clk_fall),
            .i_preset(term_val[CT_BASE + CT_PRESET]),
            .i_reset(term_val[CT_BASE + CT_RESET]),
            .o_q(mc_q[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // output buffers, pull-downs and feedback
    always_comb begin
        float_active = glb_cfg_ff.float_en && !pin_sync[SYNC_FLOAT];
        for (int m = 0; m < N_MC; m++) begin
            mc_value[m] = mc_cfg_ff[m].bypass ? mc_logic_ff[m] : mc_q[m];
            if (mc_cfg_ff[m].oe_sel < OE_ALWAYS_ON) begin
                nxt_oe[m] = term_val[CT_BASE + CT_OE_FIRST + int'(mc_cfg_ff[m].oe_sel)];
            end else begin
                nxt_oe[m] = mc_cfg_ff[m].oe_sel == OE_ALWAYS_ON;
            end
            if (mc_cfg_ff[m].pin_is_input || float_active) begin
                nxt_oe[m] = 1'b0;
            end
            // a pin unused both ways would otherwise float and burn power
            nxt_pd[m] = mc_cfg_ff[m].pulldown_en && !mc_cfg_ff[m].pin_is_input
                && mc_cfg_ff[m].oe_sel >= OE_ALWAYS_OFF;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_out_ff <= '0;
            pin_oe_ff <= '0;
            pin_pd_ff <= '0;
            feedback_ff <= '0;
        end else begin
            pin_out_ff <= mc_value;
            pin_oe_ff <= nxt_oe;
            pin_pd_ff <= nxt_pd;
            feedback_ff <= {pin_sync[SYNC_PIN_LSB +: N_MC], mc_value};
        end
    end

    assign o_pin_out = pin_out_ff;
    assign o_pin_oe = pin_oe_ff;
    assign o_pin_pulldown = pin_pd_ff;
    assign o_feedback = feedback_ff;
    assign o_avs_readdata = rdata_ff;
    assign o_avs_waitrequest = wait_ff;
endmodule

// file: src/pldb_pkg.sv
// constants, register map and configuration types of the pld logic block
package pldb_pkg;
    localparam int N_IN = 36;
    localparam int N_MC = 16;
    localparam int N_FAST = 5;
    localparam int N_SHARED = 32;
    localparam int N_CT = 6;
    localparam int N_FB = 32;
    localparam int N_CLK = 4;
    localparam int SHARED_BASE = N_MC * N_FAST;
    localparam int CT_BASE = SHARED_BASE + N_SHARED;
    localparam int N_TERM = CT_BASE + N_CT;
    localparam int ADDR_W = 12;
    localparam int CT_PRESET = 0;
    localparam int CT_RESET = 1;
    localparam int CT_OE_FIRST = 2;
    localparam int SYNC_CLK_LSB = 0;
    localparam int SYNC_FLOAT = 4;
    localparam int SYNC_PIN_LSB = 5;
    localparam int SYNC_W = 21;
    // term area: term index * 16 + sub word * 4
    localparam logic [11:0] TERM_END = 12'h760;
    localparam logic [1:0] SUB_TRUE_LO = 2'h0;
    localparam logic [1:0] SUB_TRUE_HI = 2'h1;
    localparam logic [1:0] SUB_COMP_LO = 2'h2;
    localparam logic [1:0] SUB_COMP_HI = 2'h3;
    localparam logic [11:0] MC_CFG_BASE = 12'h800;
    localparam logic [11:0] OR_MASK_BASE = 12'h840;
    localparam logic [11:0] GLB_CFG_ADDR = 12'h880;
    localparam logic [11:0] FEEDBACK_ADDR = 12'h884;
    localparam logic [11:0] PIN_STATE_ADDR = 12'h888;
    localparam logic [2:0] OE_ALWAYS_ON = 3'h4;
    localparam logic [2:0] OE_ALWAYS_OFF = 3'h5;
    localparam logic [35:0] TERM_MASK_RST = 36'hf_ffff_ffff;
    localparam logic [31:0] OR_MASK_RST = 32'h0;
    localparam int MC_CFG_W = 11;

    typedef struct packed {
        logic pulldown_en;
        logic pin_is_input;
        logic [2:0] oe_sel;
        logic bypass;
        logic pr_en;
        logic [1:0] clk_sel;
        logic falling;
        logic t_type;
    } pldb_mc_cfg_type;

    typedef struct packed {
        logic [2:0][3:0] clk_mc;
        logic rsv_b;
        logic [2:0] clk_from_logic;
        logic [6:0] rsv_a;
        logic float_en;
        logic [1:0] rsv_0;
        logic [5:0] ct_is_sum;
    } pldb_glb_cfg_type;

    localparam pldb_mc_cfg_type MC_CFG_RST = 11'h550;
    localparam pldb_glb_cfg_type GLB_CFG_RST = 32'h0;
endpackage

// file: src/pldb_sync.sv
// two-flop synchroniser for pins that arrive from outside the clock domain
`timescale 1ns/1ps
module pldb_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;
endmodule

// file: src/pldb_macrocell.sv
// one macrocell flip-flop: d or t type, clock and edge select, preset/reset
`timescale 1ns/1ps
module pldb_macrocell (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire pldb_pkg::pldb_mc_cfg_type i_cfg,
    input wire logic i_logic,
    input wire logic [pldb_pkg::N_CLK-1:0] i_rise,
    input wire logic [pldb_pkg::N_CLK-1:0] i_fall,
    input wire logic i_preset,
    input wire logic i_reset,
    output logic o_q
);
    import pldb_pkg::*;

    logic q_ff;
    logic nxt_q;
    logic edge_hit;

    assign edge_hit = i_cfg.falling ? i_fall[i_cfg.clk_sel] : i_rise[i_cfg.clk_sel];
    assign nxt_q = i_cfg.t_type ? (q_ff ^ i_logic) : i_logic;

    // preset/reset is looked at every cycle, not only on the selected edge
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q_ff <= 1'b0;
        end else if (i_cfg.pr_en && i_reset) begin
            q_ff <= 1'b0;
        end else if (i_cfg.pr_en && i_preset) begin
            q_ff <= 1'b1;
        end else if (edge_hit) begin
            q_ff <= nxt_q;
        end
    end

    assign o_q = q_ff;
endmodule

// file: test/pldb_lb_assertions.sv
// concurrent checks on the pld logic block top ports
`timescale 1ns/1ps
module pldb_lb_assertions (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [pldb_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic i_global_output_float_pin_n,
    input wire logic [pldb_pkg::N_MC-1:0] i_pin_in,
    input wire logic [pldb_pkg::N_MC-1:0] o_pin_out,
    input wire logic [pldb_pkg::N_MC-1:0] o_pin_oe,
    input wire logic [pldb_pkg::N_MC-1:0] o_pin_pulldown,
    input wire logic [pldb_pkg::N_FB-1:0] o_feedback
);
    import pldb_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // shadow of macrocell 0 config and float enable, from completed writes
    pldb_mc_cfg_type mc0_cfg_ff;
    logic float_en_ff;
    logic wr_done;
    logic unmapped;
    assign wr_done = i_avs_write && !o_avs_waitrequest;
    assign unmapped = (i_avs_address >= TERM_END && i_avs_address < MC_CFG_BASE) || i_avs_address >= 12'h88c;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mc0_cfg_ff <= MC_CFG_RST;
        end else if (wr_done && i_avs_address[11:2] == MC_CFG_BASE[11:2]) begin
            if (i_avs_byteenable[0]) mc0_cfg_ff[7:0] <= i_avs_writedata[7:0];
            if (i_avs_byteenable[1]) mc0_cfg_ff[10:8] <= i_avs_writedata[10:8];
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            float_en_ff <= 1'h0;
        end else if (wr_done && i_avs_address[11:2] == GLB_CFG_ADDR[11:2] && i_avs_byteenable[1]) begin
            float_en_ff <= i_avs_writedata[8];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_taken;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_float_held;
        (float_en_ff && !i_global_output_float_pin_n)[*4];
    endsequence
    property p_answer; s_taken |=> !o_avs_waitrequest; endproperty
    property p_wait_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
    property p_idle; !(i_avs_read || i_avs_write) && o_avs_waitrequest |=> o_avs_waitrequest; endproperty
    property p_unmapped; s_taken and (i_avs_read && unmapped) |=> o_avs_readdata == 32'h0; endproperty
    property p_float; s_float_held |-> o_pin_oe == 16'h0; endproperty
    property p_pd_excl; (o_pin_oe & o_pin_pulldown) == 16'h0; endproperty
    property p_oe_off; (mc0_cfg_ff.oe_sel >= OE_ALWAYS_OFF)[*2] |-> !o_pin_oe[0]; endproperty
    property p_oe_on;
        (mc0_cfg_ff.oe_sel == OE_ALWAYS_ON && !mc0_cfg_ff.pin_is_input && i_global_output_float_pin_n)[*5]
            |-> o_pin_oe[0];
    endproperty
    property p_fb_pin; $stable(i_pin_in)[*5] |-> o_feedback[31:16] == i_pin_in; endproperty
    property p_rst_clear; $fell(i_rst) |-> o_pin_out == 16'h0 && o_feedback[15:0] == 16'h0; endproperty
    property p_pd_reset; $fell(i_rst) |-> ##2 o_pin_pulldown == 16'hffff; endproperty
    a_answer: assert property (p_answer) else $error("bus request not answered next cycle");
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low longer than one cycle");
    a_idle: assert property (p_idle) else $error("waitrequest dropped without request");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read returned nonzero");
    a_float: assert property (p_float) else $error("outputs driven while float active");
    a_pd_excl: assert property (p_pd_excl) else $error("pull-down on a driven pin");
    a_oe_off: assert property (p_oe_off) else $error("buffer on while set always off");
    a_oe_on: assert property (p_oe_on) else $error("buffer off while set always on");
    a_fb_pin: assert property (p_fb_pin) else $error("pin feedback differs from pin level");
    a_rst_clear: assert property (p_rst_clear) else $error("flip-flops not zero after reset");
    a_pd_reset: assert property (p_pd_reset) else $error("pull-downs not on after reset");
endmodule

// file: test/pldb_board.sv
// board model: drives clock pins, float pin and external pin levels
`timescale 1ns/1ps
module pldb_board (
    input wire logic i_clk,
    input wire logic [15:0] i_pin_out,
    input wire logic [15:0] i_pin_oe,
    input wire logic [15:0] i_pin_pulldown,
    output logic o_dedicated_sync_clock,
    output logic o_clk_sel,
    output logic o_float_n,
    output logic [15:0] o_pin_in
);
    logic [15:0] drv_en;
    logic [15:0] drv_val;
    logic [15:0] float_pat;
    initial begin
        o_dedicated_sync_clock = 1'h0;
        o_clk_sel = 1'h0;
        o_float_n = 1'h1;
        drv_en = 16'h0;
        drv_val = 16'h0;
        float_pat = 16'h0;
    end
    // clock pins stand still between requested edges
    task automatic set_dedicated_sync_clock(input logic v);
        o_dedicated_sync_clock <= v;
    endtask
    task automatic set_float(input logic v);
        o_float_n <= v;
    endtask
    task automatic drive_pin(input int idx, input logic v);
        drv_en[idx] <= 1'h1;
        drv_val[idx] <= v;
    endtask
    // an undriven, unpulled pin must not look stable
    always @(posedge i_clk) begin
        float_pat <= ~float_pat;
    end
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (i_pin_oe[i]) o_pin_in[i] = i_pin_out[i];
            else if (drv_en[i]) o_pin_in[i] = drv_val[i];
            else if (i_pin_pulldown[i]) o_pin_in[i] = 1'h0;
            else o_pin_in[i] = float_pat[i];
        end
    end
endmodule

// file: test/pldb_tb.sv
// self-checking bench for the pld logic block
`timescale 1ns/1ps
bind pldb_logic_block pldb_lb_assertions u_chk (.*);
module tb;
    import pldb_pkg::*;
    localparam logic [2:0] T_IN = 3'h5;
    localparam logic [2:0] T_EXP = 3'h3;
    logic i_clk;
    logic i_rst;
    logic [11:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] rd_q;
    logic wait_req;
    logic [35:0] gia;
    logic dedicated_sync_clock;
    logic clk_sel;
    logic float_n;
    logic [15:0] pin_in;
    logic [15:0] pin_out;
    logic [15:0] pin_oe;
    logic [15:0] pin_pd;
    logic [31:0] fb;
    int err_count;
    int checks_done;
    pldb_logic_block dut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_byteenable(4'hf), .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
        .i_global_interconnect_array(gia), .i_dedicated_sync_clock(dedicated_sync_clock), .i_selectable_clock_one(clk_sel),
        .i_selectable_clock_two(clk_sel), .i_selectable_clock_three(clk_sel), .i_global_output_float_pin_n(float_n),
        .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pin_pulldown(pin_pd), .o_feedback(fb));
    pldb_board u_board (.i_clk(i_clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_pin_pulldown(pin_pd),
        .o_dedicated_sync_clock(dedicated_sync_clock), .o_clk_sel(clk_sel), .o_float_n(float_n), .o_pin_in(pin_in));
    initial i_clk = 1'h0;
    always #10 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // request held until the edge that samples waitrequest low
    task automatic bus(input logic is_rd, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        rd <= is_rd;
        wr <= !is_rd;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (wait_req !== 1'h0 && n < 20);
        rd_q = rdata;
        rd <= 1'h0;
        wr <= 1'h0;
        if (wait_req !== 1'h0) begin
            err_count++;
            stop_test();
        end
    endtask
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        bus(1'h0, a, d);
    endtask
    task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        bus(1'h1, a, 32'h0);
        chk(name, rd_q, exp);
    endtask
    task automatic wterm(input int t, input logic [31:0] lo);
        logic [11:0] a;
        a = 12'(t * 16);
        wreg(a, lo);
        wreg(a + 12'h4, 32'h0);
        wreg(a + 12'h8, 32'h0);
        wreg(a + 12'hc, 32'h0);
    endtask
    task automatic set_in(input int idx, input logic v);
        @(posedge i_clk);
        gia[idx] <= v;
    endtask
    // eight cycles: sync, edge detect, output register, then pin sync back to feedback
    task automatic clk_edge(input logic v);
        @(posedge i_clk);
        u_board.set_dedicated_sync_clock(v);
        repeat (8) @(posedge i_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_rst = 1'h1;
        addr = 12'h0;
        rd = 1'h0;
        wr = 1'h0;
        wdata = 32'h0;
        gia = 36'h0;
        err_count = 0;
        checks_done = 0;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'h0;
        rchk("mc cfg reset", MC_CFG_BASE, 32'(MC_CFG_RST));
        rchk("or mask reset", OR_MASK_BASE, OR_MASK_RST);
        rchk("global reset", GLB_CFG_ADDR, 32'h0);
        rchk("term lo reset", 12'h000, TERM_MASK_RST[31:0]);
        rchk("term hi reset", 12'h004, 32'(TERM_MASK_RST[35:32]));
        wreg(12'h780, 32'hffff_ffff);
        rchk("unmapped", 12'h780, 32'h0);
        chk("flops at reset", {pin_out, fb[15:0]}, 32'h0);
        chk("pulldown at reset", pin_pd, 16'hffff);
        wterm(0, 32'h1);
        wreg(MC_CFG_BASE, 32'h110);
        set_in(0, 1'h1);
        clk_edge(1'h1);
        chk("d capture", {pin_out[0], fb[0], fb[16], pin_oe[0]}, 4'hf);
        clk_edge(1'h0);
        set_in(0, 1'h0);
        clk_edge(1'h1);
        chk("d clear", {pin_out[0], fb[0]}, 2'h0);
        clk_edge(1'h0);
        wreg(MC_CFG_BASE, 32'h111);
        for (int k = 0; k < 3; k++) begin
            set_in(0, T_IN[k]);
            clk_edge(1'h1);
            clk_edge(1'h0);
            chk("toggle", pin_out[0], T_EXP[k]);
        end
        wreg(MC_CFG_BASE, 32'h113);
        set_in(0, 1'h1);
        clk_edge(1'h1);
        chk("no rise capture", pin_out[0], 1'h0);
        clk_edge(1'h0);
        chk("fall capture", pin_out[0], 1'h1);
        // shared term alone drives both macrocells
        wreg(MC_CFG_BASE, 32'h110);
        set_in(0, 1'h0);
        wterm(N_MC * N_FAST, 32'h2);
        wreg(OR_MASK_BASE, 32'h1);
        wreg(OR_MASK_BASE + 12'h4, 32'h1);
        wreg(MC_CFG_BASE + 12'h4, 32'h100);
        set_in(1, 1'h1);
        clk_edge(1'h1);
        clk_edge(1'h0);
        chk("shared term", pin_out[1:0], 2'h3);
        wterm(CT_BASE + CT_RESET, 32'h4);
        set_in(2, 1'h1);
        repeat (4) @(posedge i_clk);
        chk("reset without clock", pin_out[0], 1'h0);
        chk("reset disabled", pin_out[1], 1'h1);
        set_in(2, 1'h0);
        wterm(CT_BASE + CT_OE_FIRST, 32'h8);
        wreg(MC_CFG_BASE, 32'h010);
        repeat (4) @(posedge i_clk);
        chk("oe term low", pin_oe[0], 1'h0);
        set_in(3, 1'h1);
        repeat (4) @(posedge i_clk);
        chk("oe term high", pin_oe[0], 1'h1);
        wreg(GLB_CFG_ADDR, 32'h100);
        @(posedge i_clk);
        u_board.set_float(1'h0);
        repeat (6) @(posedge i_clk);
        chk("float oe", pin_oe, 16'h0);
        rchk("float state", PIN_STATE_ADDR, 32'h1_0000);
        @(posedge i_clk);
        u_board.set_float(1'h1);
        repeat (6) @(posedge i_clk);
        chk("float released", pin_oe[0], 1'h1);
        wreg(MC_CFG_BASE + 12'h8, 32'h740);
        @(posedge i_clk);
        u_board.drive_pin(2, 1'h1);
        repeat (6) @(posedge i_clk);
        chk("input pin", {fb[18], pin_oe[2], pin_pd[2]}, 3'h4);
        chk("unused pin pulldown", pin_pd[3], 1'h1);
        stop_test();
    end
endmodule
